// file: design/bee_ctrl.sv
// Byte nonvolatile data memory access controller with AXI4-Lite registers.
// Assumes one clock, synchronous active-low reset, CPU stall sampled outside.
`timescale 1ns/1ps
module bee_ctrl (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Processor side.
  output logic             cpu_stall,
  output logic             irq
);
  import bee_pkg::*;

  typedef enum logic [1:0] {
    BEE_IDLE  = 2'b00,
    BEE_ERASE = 2'b01,
    BEE_WRITE = 2'b10
  } bee_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic [7:0]         mem_r [BEE_DEPTH];
  logic [BEE_AW-1:0]  addr_r, addr_nxt;
  logic [7:0]         data_r, data_nxt;
  logic [1:0]         mode_r, mode_nxt;
  logic               arm_r, arm_nxt;
  logic [2:0]         armc_r, armc_nxt;
  logic [2:0]         stall_r, stall_nxt;
  bee_state_t         st_r, st_nxt;
  logic [1:0]         sts_r, sts_nxt;
  logic [1:0]         msk_r, msk_nxt;
  logic               aw_r, aw_nxt, w_r, w_nxt;
  logic [7:0]         awa_r, awa_nxt;
  logic [31:0]        wd_r, wd_nxt;
  logic               bv_r, bv_nxt, be_r, be_nxt;
  logic               rv_r, rv_nxt, re_r, re_nxt;
  logic [31:0]        rd_r, rd_nxt;
  logic               tstart, tdone;
  logic               wr_go, busy, rd_go, prog_go, do_mem;
  logic [7:0]         mem_wval;

  assign busy = (st_r != BEE_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are latched in either order.
  assign s_axi_awready = !aw_r && !bv_r;
  assign s_axi_wready  = !w_r && !bv_r;
  assign wr_go         = aw_r && w_r && !bv_r;

  // Register writes, strobes, arming window and the programming engine.
  always_comb begin
    aw_nxt    = aw_r;
    w_nxt     = w_r;
    awa_nxt   = awa_r;
    wd_nxt    = wd_r;
    bv_nxt    = bv_r && !s_axi_bready;
    be_nxt    = be_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    mode_nxt  = mode_r;
    arm_nxt   = arm_r;
    armc_nxt  = armc_r;
    stall_nxt = (stall_r != 3'h0) ? stall_r - 3'h1 : 3'h0;
    st_nxt    = st_r;
    sts_nxt   = sts_r;
    msk_nxt   = msk_r;
    tstart    = 1'b0;
    rd_go     = 1'b0;
    prog_go   = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_nxt  = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_nxt  = 1'b1;
      wd_nxt = s_axi_wdata;
    end
    // Arm bit self-clears after its window.
    if (arm_r) begin
      if (armc_r == BEE_ARM_WIN - 3'h1) begin
        arm_nxt = 1'b0;
      end else begin
        armc_nxt = armc_r + 3'h1;
      end
    end
    if (wr_go) begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      bv_nxt = 1'b1;
      be_nxt = 1'b0;
      case (awa_r)
        BEE_OFF_CTRL: begin
          if (!busy && wd_r[BEE_B_READ]) begin
            rd_go     = 1'b1;
            stall_nxt = BEE_RD_STALL;
          end else if (!busy && wd_r[BEE_B_PROG] && arm_r
                       && mode_r != 2'b11) begin
            prog_go   = 1'b1;
            tstart    = 1'b1;
            arm_nxt   = 1'b0;
            stall_nxt = BEE_WR_STALL;
            // Atomic and erase modes start with the erase phase.
            st_nxt = (mode_r == BEE_MODE_WRITE) ? BEE_WRITE : BEE_ERASE;
          end else if (!busy && wd_r[BEE_B_ARM]) begin
            arm_nxt  = 1'b1;
            armc_nxt = 3'h0;
          end
          // A starting strobe keeps the mode, so its phases stay the same.
          if (!busy && !prog_go) begin
            mode_nxt = wd_r[BEE_B_MODE+:2];
          end
        end
        // Address and data stay frozen while programming is under way.
        BEE_OFF_ADDR: if (!busy) addr_nxt = wd_r[BEE_AW-1:0];
        BEE_OFF_DATA: if (!busy) data_nxt = wd_r[7:0];
        BEE_OFF_STAT: sts_nxt = sts_r & ~wd_r[1:0];
        BEE_OFF_MASK: msk_nxt = wd_r[1:0];
        default:      be_nxt = 1'b1;
      endcase
    end
    if (rd_go) begin
      sts_nxt[0] = 1'b1;
    end
    // Phase sequencing; the refused start case sets the error flag.
    if (wr_go && awa_r == BEE_OFF_CTRL && busy
        && (wd_r[BEE_B_READ] || wd_r[BEE_B_PROG])) begin
      sts_nxt[1] = 1'b1;
    end
    if (tdone) begin
      if (st_r == BEE_ERASE && mode_r == BEE_MODE_ATOMIC) begin
        st_nxt = BEE_WRITE;
        tstart = 1'b1;
      end else begin
        st_nxt     = BEE_IDLE;
        sts_nxt[0] = 1'b1;
      end
    end
  end

  // Byte written into the array at the end of a phase.
  assign do_mem   = tdone && busy;
  // Write only ANDs into the cell, so an unerased byte ends up mixed.
  assign mem_wval = (st_r == BEE_ERASE) ? 8'hFF
                                        : (mem_r[addr_r] & data_r);

  // Bus side, arm, stall, status and mask registers follow bus reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r    <= 1'b0;
      w_r     <= 1'b0;
      awa_r   <= 8'h00;
      wd_r    <= BEE_RST_ZERO;
      bv_r    <= 1'b0;
      be_r    <= 1'b0;
      arm_r   <= 1'b0;
      armc_r  <= 3'h0;
      stall_r <= 3'h0;
      sts_r   <= 2'b00;
      msk_r   <= 2'b00;
    end else begin
      aw_r    <= aw_nxt;
      w_r     <= w_nxt;
      awa_r   <= awa_nxt;
      wd_r    <= wd_nxt;
      bv_r    <= bv_nxt;
      be_r    <= be_nxt;
      arm_r   <= arm_nxt;
      armc_r  <= armc_nxt;
      stall_r <= stall_nxt;
      sts_r   <= sts_nxt;
      msk_r   <= msk_nxt;
    end
  end

  // The engine ignores reset so a started operation still completes.
  // Address, data and mode registers are frozen while busy, so the held
  // values stay valid; only after completion does reset take them.
  always_ff @(posedge aclk) begin
    if (!aresetn && !busy) begin
      st_r   <= BEE_IDLE;
      addr_r <= '0;
      data_r <= 8'h00;
      mode_r <= 2'b00;
    end else begin
      st_r   <= st_nxt;
      addr_r <= addr_nxt;
      data_r <= rd_go ? mem_r[addr_r] : data_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Array storage, one byte per entry.
  for (genvar gi = 0; gi < BEE_DEPTH; gi++) begin : g_mem
    always_ff @(posedge aclk) begin
      if (do_mem && addr_r == BEE_AW'(gi)) begin
        mem_r[gi] <= mem_wval;
      end
    end
  end

  bee_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn || busy),
    .start   (tstart),
    .ticks   (BEE_PHASE_TICKS),
    .done    (tdone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path.
  assign s_axi_arready = !rv_r;

  always_comb begin
    rv_nxt = rv_r && !s_axi_rready;
    re_nxt = re_r;
    rd_nxt = rd_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_nxt = 1'b1;
      re_nxt = 1'b0;
      case (s_axi_araddr)
        // Program strobe bit mirrors the busy engine.
        BEE_OFF_CTRL: rd_nxt = {26'h0, mode_r, 1'b0, arm_r, busy,
                                1'b0};
        BEE_OFF_ADDR: rd_nxt = {23'h0, addr_r};
        BEE_OFF_DATA: rd_nxt = {24'h0, data_r};
        BEE_OFF_STAT: rd_nxt = {30'h0, sts_r};
        BEE_OFF_MASK: rd_nxt = {30'h0, msk_r};
        default: begin
          rd_nxt = BEE_RST_ZERO;
          re_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_r <= 1'b0;
      re_r <= 1'b0;
      rd_r <= BEE_RST_ZERO;
    end else begin
      rv_r <= rv_nxt;
      re_r <= re_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp  = be_r ? BEE_RESP_ERR : BEE_RESP_OK;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata  = rd_r;
  assign s_axi_rresp  = re_r ? BEE_RESP_ERR : BEE_RESP_OK;
  assign cpu_stall    = (stall_r != 3'h0);
  assign irq          = |(sts_r & msk_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_rd_start;
    wr_go && awa_r == BEE_OFF_CTRL && !busy && wd_r[BEE_B_READ];
  endsequence

  a_read_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_start |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  a_prog_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("program stall not two cycles");
  a_arm_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(arm_r) |-> ##[1:4] !arm_r)
    else $error("arm bit outlived window");
  a_refuse_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    busy |-> !rd_go && !prog_go)
    else $error("operation started while busy");
  a_read_data: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go |=> data_r == mem_r[addr_r])
    else $error("read data mismatch");
  a_refuse_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && awa_r == BEE_OFF_CTRL && busy && wd_r[BEE_B_READ]
    |=> sts_r[1])
    else $error("refused strobe not flagged");
  a_erase_only: assert property (@(posedge aclk) disable iff (!aresetn)
    do_mem && mode_r == BEE_MODE_ERASE |-> ##1 st_r == BEE_IDLE)
    else $error("erase-only did not finish");
  a_atomic_seq: assert property (@(posedge aclk) disable iff (!aresetn)
    tdone && st_r == BEE_ERASE && mode_r == BEE_MODE_ATOMIC
    |=> st_r == BEE_WRITE)
    else $error("atomic write phase missing");
  a_write_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_go && mode_r == BEE_MODE_WRITE |=> st_r == BEE_WRITE)
    else $error("write-only did not skip erase");
  a_busy_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    tdone && st_r == BEE_WRITE |=> !busy)
    else $error("busy did not end");
endmodule // bee_ctrl

// file: design/bee_pkg.sv
// Package for the byte nonvolatile access controller.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register bus.
package bee_pkg;
  // Geometry of the nonvolatile array.
  localparam int unsigned BEE_AW    = 9;
  localparam int unsigned BEE_DEPTH = 512;
  // Register byte offsets.
  localparam logic [7:0] BEE_OFF_CTRL = 8'h00;
  localparam logic [7:0] BEE_OFF_ADDR = 8'h04;
  localparam logic [7:0] BEE_OFF_DATA = 8'h08;
  localparam logic [7:0] BEE_OFF_STAT = 8'h0C;
  localparam logic [7:0] BEE_OFF_MASK = 8'h10;
  // Control field positions.
  localparam int unsigned BEE_B_READ  = 0;
  localparam int unsigned BEE_B_PROG  = 1;
  localparam int unsigned BEE_B_ARM   = 2;
  localparam int unsigned BEE_B_MODE  = 4;
  // Programming modes.
  typedef enum logic [1:0] {
    BEE_MODE_ATOMIC = 2'b00,
    BEE_MODE_ERASE  = 2'b01,
    BEE_MODE_WRITE  = 2'b10
  } bee_mode_t;
  // Cycle counts.
  localparam logic [2:0] BEE_RD_STALL  = 3'h4;
  localparam logic [2:0] BEE_WR_STALL  = 3'h2;
  localparam logic [2:0] BEE_ARM_WIN   = 3'h4;
  // Programming time per phase in microseconds; oscillator tick period.
  localparam int unsigned BEE_T_PHASE_US = 2;
  localparam int unsigned BEE_CLK_MHZ    = 250;
  localparam int unsigned BEE_OSC_DIV    = 32;
  localparam int unsigned BEE_PHASE_CYC  = BEE_T_PHASE_US * BEE_CLK_MHZ;
  localparam logic [15:0] BEE_PHASE_TICKS =
    16'((BEE_PHASE_CYC + BEE_OSC_DIV - 1) / BEE_OSC_DIV);
  localparam logic [7:0]  BEE_OSC_LAST = 8'(BEE_OSC_DIV - 1);
  // Reset values.
  localparam logic [31:0] BEE_RST_ZERO = 32'h0000_0000;
  // AXI response codes.
  localparam logic [1:0] BEE_RESP_OK  = 2'b00;
  localparam logic [1:0] BEE_RESP_ERR = 2'b10;
endpackage

// file: design/bee_timer.sv
// Programming timer paced by a free-running tick divided down from aclk.
// Assumes start is a one-cycle pulse on aclk.
`timescale 1ns/1ps
module bee_timer (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control.
  input  wire logic        start,
  input  wire logic [15:0] ticks,
  // Status.
  output logic             done
);
  import bee_pkg::*;

  logic [7:0]  osc_r;
  logic [7:0]  osc_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        done_r;
  logic        done_nxt;

  // The divider free-runs like an oscillator; the count ends the busy phase.
  always_comb begin
    osc_nxt  = (osc_r == BEE_OSC_LAST) ? 8'h00 : osc_r + 8'h01;
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = ticks;
      run_nxt = 1'b1;
    end else if (run_r && osc_r == BEE_OSC_LAST) begin
      if (cnt_r <= 16'h0001) begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_r  <= 8'h00;
      cnt_r  <= 16'h0000;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      osc_r  <= osc_nxt;
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule // bee_timer

// file: dv/bee_cpu.sv
// Processor-side model: an AXI4-Lite master with register access tasks.
// Assumes the controller's slave port and a free-running aclk.
`timescale 1ns/1ps
module bee_cpu (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels.
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  import bee_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Answers are always taken at once, so bready and rready stay high.
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
  end
  // Word write; each channel is released at its own handshake edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready === 1'b1) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready === 1'b1) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge aclk);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
  endtask
  // Word read; data is taken at the edge that sees rvalid.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Address and data go first; arm carries the mode, strobe follows.
  task automatic prog(input logic [8:0] a, input logic [7:0] d,
                      input logic [1:0] m);
    logic [1:0] r;
    wr(BEE_OFF_ADDR, 32'(a), r);
    wr(BEE_OFF_DATA, 32'(d), r);
    wr(BEE_OFF_CTRL, {26'h0, m, 4'h4}, r);
    wr(BEE_OFF_CTRL, 32'h0000_0002, r);
  endtask
endmodule // bee_cpu

// file: dv/test_byte_eeprom_access_ctrl.sv
// Self-checking bench for the byte nonvolatile access controller.
// Assumes bee_pkg, bee_ctrl and the bee_cpu master are compiled first.
`timescale 1ns/1ps
module test_byte_eeprom_access_ctrl;
  import bee_pkg::*;
  logic        aclk, aresetn, cpu_stall, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [8:0]  a;
  logic [7:0]  mem [BEE_DEPTH];
  int          failures, check_count, stall_n, seed;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, instances and a count of stalled cycles.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  bee_ctrl DUT (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .cpu_stall     (cpu_stall),
    .irq           (irq)
  );
  bee_cpu cpu (
    .aclk          (aclk),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );
  always @(posedge aclk) if (cpu_stall === 1'b1) stall_n++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Busy must read set at first, then clear when the timer expires.
  task automatic wait_idle();
    cpu.rd(BEE_OFF_CTRL, v, r);
    chk(v[1], 1'b1);
    while (v[1] !== 1'b0) cpu.rd(BEE_OFF_CTRL, v, r);
  endtask
  // Programs one byte; bad adds a refused read strobe while busy.
  task automatic prog(input logic [8:0] ad, input logic [7:0] dd,
                      input logic [1:0] m, input bit bad);
    stall_n = 0;
    cpu.prog(ad, dd, m);
    if (bad) begin
      cpu.wr(BEE_OFF_CTRL, 32'h1, r);
      cpu.rd(BEE_OFF_STAT, v, r);
      chk(v, 32'h2);
      chk(irq, 1'b1);
    end
    wait_idle();
    chk(stall_n, 2);
    if (m == 2'b00) mem[ad] = dd;
    else if (m == 2'b01) mem[ad] = 8'hFF;
    else mem[ad] = mem[ad] & dd;
  endtask
  // Read strobe, wait out the stall, then collect the data register.
  task automatic rd_byte(input logic [8:0] ad);
    cpu.wr(BEE_OFF_ADDR, 32'(ad), r);
    stall_n = 0;
    cpu.wr(BEE_OFF_CTRL, 32'h1, r);
    @(posedge aclk);
    for (int i = 0; i < 20 && cpu_stall !== 1'b0; i++) @(posedge aclk);
    cpu.rd(BEE_OFF_DATA, v, r);
    chk(v, {24'h0, mem[ad]});
    chk(stall_n, 4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the programming time of all tests.
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    final_report();
  end
  // Main sequence.
  initial begin
    seed = 32'h9EDB;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
      cpu.rd(8'(i * 4), v, r);
      chk(v, BEE_RST_ZERO); // [regs]
    end
    cpu.rd(8'h14, v, r);
    chk({v, r}, {32'h0, BEE_RESP_ERR}); // [regs]
    cpu.wr(8'h14, 32'h5A, r);
    chk(r, BEE_RESP_ERR); // [regs]
    $display("test reset_map done");
    // Each mode on random bytes and the top address; erase precedes write.
    for (int k = 0; k < 4; k++) begin
      a = (k == 3) ? 9'h1FF : 9'($random(seed));
      d = 8'($random(seed));
      prog(a, d, BEE_MODE_ATOMIC, 1'b0);
      rd_byte(a);
      prog(a, 8'h00, BEE_MODE_ERASE, 1'b0);
      rd_byte(a);
      prog(a, ~d, BEE_MODE_WRITE, 1'b0);
      rd_byte(a);
    end
    $display("test modes done");
    // Refused strobe while busy, then status, mask and clear.
    cpu.wr(BEE_OFF_MASK, 32'h3, r);
    cpu.wr(BEE_OFF_STAT, 32'h3, r);
    prog(a, d, BEE_MODE_ATOMIC, 1'b1);
    rd_byte(a);
    cpu.wr(BEE_OFF_MASK, 32'h0, r);
    cpu.rd(BEE_OFF_STAT, v, r);
    chk({v, irq}, {32'h3, 1'b0}); // [irq]
    cpu.wr(BEE_OFF_MASK, 32'h1, r);
    cpu.rd(BEE_OFF_MASK, v, r);
    chk({v, irq}, {32'h1, 1'b1}); // [irq]
    cpu.wr(BEE_OFF_STAT, 32'h3, r);
    cpu.rd(BEE_OFF_STAT, v, r);
    chk({v, irq}, {32'h0, 1'b0}); // [irq]
    $display("test refuse_irq done");
    // A strobe after the arm window closed starts nothing.
    cpu.wr(BEE_OFF_CTRL, 32'h4, r);
    repeat (6) @(posedge aclk);
    cpu.wr(BEE_OFF_CTRL, 32'h2, r);
    cpu.rd(BEE_OFF_CTRL, v, r);
    chk(v[1], 1'b0);
    $display("test arm_window done");
    // Reset in mid-programming must not abort the operation.
    a = 9'($random(seed));
    d = 8'($random(seed));
    cpu.prog(a, d, BEE_MODE_ATOMIC);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wait_idle();
    mem[a] = d;
    rd_byte(a);
    $display("test reset_busy done");
    final_report();
  end
endmodule // test_byte_eeprom_access_ctrl
